// *** rtl/rtcs_pkg.sv ***
// Constants shared by the reload timer clock-select block.
// Assumes a single 100 MHz system clock and AXI4-Lite register access.
`default_nettype none
package rtcs_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Register byte offsets.
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_MODE    = 8'h04;
	localparam logic [7:0] OFF_RELOAD  = 8'h08;
	localparam logic [7:0] OFF_COUNT   = 8'h0C;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	// Field positions.
	localparam int unsigned CTL_EXP_DIS_BIT = 3;
	localparam int unsigned CTL_SEL_HI_BIT  = 0;
	localparam int unsigned MODE_SEL_MID_BIT = 3;
	localparam int unsigned MODE_SEL_LO_BIT  = 2;
	localparam int unsigned MODE_EDGE_BIT    = 0;
	localparam int unsigned STAT_UNDER_BIT   = 1;
	localparam int unsigned STAT_RSVD_BIT    = 0;
	// Values after reset.
	localparam logic [7:0] CONTROL_RESET = 8'h09;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] RELOAD_RESET  = 8'hFF;
	// Prescaler tap exponents: the tap divides the clock by two to the power given.
	localparam int unsigned PRESC_WIDTH = 14;
	localparam int unsigned TAP_DIV128   = 7;
	localparam int unsigned TAP_DIV64    = 6;
	localparam int unsigned TAP_DIV16384 = 14;
	localparam int unsigned TAP_DIV2048  = 11;
	localparam int unsigned TAP_DIV1024  = 10;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rtcs_pkg
`default_nettype wire

// *** rtl/rtcs_sel_if.sv ***
// Interface carrying clock-select settings and the count tick between modules.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface rtcs_sel_if;
	logic expansion_disable;
	logic second_clk_sel_hi;
	logic second_clk_sel_mid;
	logic second_clk_sel_lo;
	logic edge_fall;
	logic first_underflow;
	logic ext_pin;
	logic count_tick;
	logic reserved_sel;
	modport ctrl (
		output expansion_disable, second_clk_sel_hi, second_clk_sel_mid, second_clk_sel_lo,
		output edge_fall, first_underflow, ext_pin,
		input  count_tick, reserved_sel
	);
	modport sel (
		input  expansion_disable, second_clk_sel_hi, second_clk_sel_mid, second_clk_sel_lo,
		input  edge_fall, first_underflow, ext_pin,
		output count_tick, reserved_sel
	);
endinterface : rtcs_sel_if
`default_nettype wire

// *** rtl/rtcs_src_sel.sv ***
// System prescaler, external pin edge detector and count-source selector.
// Assumes synchronous active-low reset and inputs carried by rtcs_sel_if.
`timescale 1ns/1ps
`default_nettype none
module rtcs_src_sel (
	// Clock and reset.
	input  wire logic  aclk,
	input  wire logic  aresetn,
	// Settings in, tick out.
	rtcs_sel_if.sel    sel_bus
);
	logic [rtcs_pkg::PRESC_WIDTH-1:0] presc;
	logic [rtcs_pkg::PRESC_WIDTH:0]   tap_ones;
	logic                             pin_meta;
	logic                             pin_sync;
	logic                             pin_prev;
	logic                             pin_edge;
	logic                             presc_tick;
	logic                             reserved;
	logic                             next_tick;

	// Tap k is high when the low k prescaler bits are all ones, once every 2^k cycles.
	assign tap_ones[0] = 1'b1;
	genvar k;
	generate
		for (k = 0; k < rtcs_pkg::PRESC_WIDTH; k++) begin : g_tap
			assign tap_ones[k+1] = tap_ones[k] & presc[k];
		end
	endgenerate

	assign reserved   = ~sel_bus.expansion_disable & ~sel_bus.second_clk_sel_hi;
	assign presc_tick = !sel_bus.expansion_disable
		? (sel_bus.second_clk_sel_lo ? tap_ones[rtcs_pkg::TAP_DIV64] : tap_ones[rtcs_pkg::TAP_DIV128])
		: (sel_bus.second_clk_sel_hi
			? (sel_bus.second_clk_sel_lo ? tap_ones[rtcs_pkg::TAP_DIV2048]
				: tap_ones[rtcs_pkg::TAP_DIV16384])
			: tap_ones[rtcs_pkg::TAP_DIV1024]);
	assign pin_edge   = sel_bus.edge_fall ? (pin_prev & ~pin_sync) : (~pin_prev & pin_sync);
	assign next_tick  = reserved ? 1'b0
		: (!sel_bus.second_clk_sel_mid ? presc_tick
		: (sel_bus.second_clk_sel_lo ? pin_edge : sel_bus.first_underflow));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc    <= '0;
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
			sel_bus.count_tick   <= 1'b0;
			sel_bus.reserved_sel <= 1'b0;
		end else begin
			presc    <= presc + 1'b1;
			pin_meta <= sel_bus.ext_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			sel_bus.count_tick   <= next_tick;
			sel_bus.reserved_sel <= reserved;
		end
	end
endmodule : rtcs_src_sel
`default_nettype wire

// *** rtl/rtcs_top.sv ***
// Second reload timer with count-source selection, reached over AXI4-Lite.
// Assumes one 100 MHz clock, synchronous inputs and an AXI4-Lite master.
//
// Functional notes
// - Control bit 3 clear enables timer expansion.
// - Expansion-disable bit reads 1 after reset.
// - Four select bits jointly choose count source.
// - Expansion on: /128, /64; select-high 0 reserved.
// - Expansion off, select-high 1: /16384, /2048.
// - Expansion off, select-high 0: /1024 both.
// - Mode pair 10 cascades first timer underflow.
// - Mode pair 11 counts external pin edges.
// - Evaluation variant pins expansion-disable at 1.
`timescale 1ns/1ps
`default_nettype none
module rtcs_top #(
	parameter bit EVAL_CHIP = 1'b0
) (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data.
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data.
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Timer events and pin.
	input  wire logic        first_underflow,
	input  wire logic        external_interrupt_two_pin,
	output logic             second_underflow
);
	rtcs_sel_if sel_bus ();

	logic [7:0]  timer_pair_control;
	logic [7:0]  timer_pair_mode;
	logic [7:0]  reload;
	logic [7:0]  count;
	logic        under_flag;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_got;
	logic        w_got;

	wire         do_write  = aw_got & w_got & ~s_axi_bvalid;
	wire         wr_lane0  = do_write & w_strb[0];
	wire         wr_ctl    = wr_lane0 && (aw_addr == rtcs_pkg::OFF_CONTROL);
	wire         wr_mode   = wr_lane0 && (aw_addr == rtcs_pkg::OFF_MODE);
	wire         wr_reload = wr_lane0 && (aw_addr == rtcs_pkg::OFF_RELOAD);
	wire         wr_stat   = wr_lane0 && (aw_addr == rtcs_pkg::OFF_STATUS);
	wire         wr_ok     = (aw_addr == rtcs_pkg::OFF_CONTROL) || (aw_addr == rtcs_pkg::OFF_MODE)
		|| (aw_addr == rtcs_pkg::OFF_RELOAD) || (aw_addr == rtcs_pkg::OFF_COUNT)
		|| (aw_addr == rtcs_pkg::OFF_STATUS);
	wire         rd_take   = s_axi_arvalid & s_axi_arready;
	wire [7:0]   ctl_view  = EVAL_CHIP ? (timer_pair_control | (8'h01 << rtcs_pkg::CTL_EXP_DIS_BIT))
		: timer_pair_control;
	wire [7:0]   next_ctl  = EVAL_CHIP ? (w_data[7:0] | (8'h01 << rtcs_pkg::CTL_EXP_DIS_BIT))
		: w_data[7:0];
	logic [7:0]  stat_view;
	wire         rd_ok;
	wire [31:0]  rd_word;
	wire         tick       = sel_bus.count_tick;
	wire         wrap       = tick && (count == 8'h00);
	wire [7:0]   next_count = wr_reload ? w_data[7:0] : (wrap ? reload : count - 8'h01);

	// Read decode.
	assign rd_ok   = (s_axi_araddr == rtcs_pkg::OFF_CONTROL) || (s_axi_araddr == rtcs_pkg::OFF_MODE)
		|| (s_axi_araddr == rtcs_pkg::OFF_RELOAD) || (s_axi_araddr == rtcs_pkg::OFF_COUNT)
		|| (s_axi_araddr == rtcs_pkg::OFF_STATUS);
	assign rd_word = (s_axi_araddr == rtcs_pkg::OFF_CONTROL) ? {24'h000000, ctl_view}
		: (s_axi_araddr == rtcs_pkg::OFF_MODE)   ? {24'h000000, timer_pair_mode}
		: (s_axi_araddr == rtcs_pkg::OFF_RELOAD) ? {24'h000000, reload}
		: (s_axi_araddr == rtcs_pkg::OFF_COUNT)  ? {24'h000000, count}
		: (s_axi_araddr == rtcs_pkg::OFF_STATUS) ? {24'h000000, stat_view}
		: 32'h00000000;

	// Status bits placed at their field positions.
	always_comb begin
		stat_view                           = 8'h00;
		stat_view[rtcs_pkg::STAT_UNDER_BIT] = under_flag;
		stat_view[rtcs_pkg::STAT_RSVD_BIT]  = sel_bus.reserved_sel;
	end

	// Refuse field positions and taps that the 8-bit registers and the prescaler cannot hold.
	generate
		if (rtcs_pkg::CTL_EXP_DIS_BIT > 7 || rtcs_pkg::CTL_SEL_HI_BIT > 7) begin : g_bad_ctl
			$error("Control field position lies outside the register.");
		end
		if (rtcs_pkg::MODE_SEL_MID_BIT > 7 || rtcs_pkg::MODE_SEL_LO_BIT > 7
			|| rtcs_pkg::MODE_EDGE_BIT > 7) begin : g_bad_mode
			$error("Mode field position lies outside the register.");
		end
		if (rtcs_pkg::STAT_UNDER_BIT > 7 || rtcs_pkg::STAT_RSVD_BIT > 7) begin : g_bad_stat
			$error("Status field position lies outside the register.");
		end
		if (rtcs_pkg::TAP_DIV16384 > rtcs_pkg::PRESC_WIDTH) begin : g_bad_tap
			$error("Prescaler is too narrow for the slowest tap.");
		end
	endgenerate

	// Settings to the source selector.
	assign sel_bus.expansion_disable  = ctl_view[rtcs_pkg::CTL_EXP_DIS_BIT];
	assign sel_bus.second_clk_sel_hi  = timer_pair_control[rtcs_pkg::CTL_SEL_HI_BIT];
	assign sel_bus.second_clk_sel_mid = timer_pair_mode[rtcs_pkg::MODE_SEL_MID_BIT];
	assign sel_bus.second_clk_sel_lo  = timer_pair_mode[rtcs_pkg::MODE_SEL_LO_BIT];
	assign sel_bus.edge_fall          = timer_pair_mode[rtcs_pkg::MODE_EDGE_BIT];
	assign sel_bus.first_underflow    = first_underflow;
	assign sel_bus.ext_pin            = external_interrupt_two_pin;

	rtcs_src_sel u_src_sel (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sel_bus (sel_bus)
	);

	// Write channel capture and response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= rtcs_pkg::RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_got        <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_got        <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? rtcs_pkg::RESP_OKAY : rtcs_pkg::RESP_SLVERR;
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channel.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= rtcs_pkg::RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_ok ? rtcs_pkg::RESP_OKAY : rtcs_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// Software registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_pair_control <= rtcs_pkg::CONTROL_RESET;
			timer_pair_mode    <= rtcs_pkg::MODE_RESET;
			reload             <= rtcs_pkg::RELOAD_RESET;
		end else begin
			if (wr_ctl) begin
				timer_pair_control <= next_ctl;
			end
			if (wr_mode) begin
				timer_pair_mode <= w_data[7:0];
			end
			if (wr_reload) begin
				reload <= w_data[7:0];
			end
		end
	end

	// Second reload timer: counts down on each selected tick and reloads on underflow.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count            <= rtcs_pkg::RELOAD_RESET;
			second_underflow <= 1'b0;
			under_flag       <= 1'b0;
		end else begin
			if (wr_reload || tick) begin
				count <= next_count;
			end
			second_underflow <= wrap;
			if (wrap) begin
				under_flag <= 1'b1;
			end else if (wr_stat && w_data[rtcs_pkg::STAT_UNDER_BIT]) begin
				under_flag <= 1'b0;
			end
		end
	end
endmodule : rtcs_top
`default_nettype wire

// *** sim/rtcs_top_checker.sv ***
// Concurrent checks on the ports of the reload timer clock-select block.
// Assumes it is bound to every rtcs_top instance and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module rtcs_top_checker #(
	parameter bit EVAL_CHIP = 1'b0
) (
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus and timer signals.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        second_underflow
);
	logic [7:0] rd_addr;
	wire        rd_mapped = (rd_addr <= 8'h10) && (rd_addr[1:0] == 2'h0);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Holds the address of the read now being answered.
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			rd_addr <= s_axi_araddr;
		end
	end
	property p_eval_fixed;
		s_axi_rvalid && rd_addr == rtcs_pkg::OFF_CONTROL && EVAL_CHIP |-> s_axi_rdata[3];
	endproperty
	a_eval_fixed: assert property (p_eval_fixed) else $error("expansion disable read as 0");
	property p_unmapped;
		s_axi_rvalid && !rd_mapped |-> s_axi_rresp == rtcs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_mapped;
		s_axi_rvalid && rd_mapped |-> s_axi_rresp == rtcs_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped read bad response");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_ranswer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_ranswer: assert property (p_ranswer) else $error("read not answered");
	property p_wanswer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wanswer: assert property (p_wanswer) else $error("write not answered");
	property p_rst_quiet;
		disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !second_underflow;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
endmodule : rtcs_top_checker
bind rtcs_top rtcs_top_checker #(.EVAL_CHIP(EVAL_CHIP)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .second_underflow(second_underflow));
`default_nettype wire

// *** sim/rtcs_top_tb.sv ***
// Self-checking bench for the reload timer clock-select block.
// Assumes the checker file is compiled with it; an evaluation instance shares all inputs.
`timescale 1ns/1ps
`default_nettype none
module rtcs_top_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, fu = 1'b0, pin = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, e_rdata, erd;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, sund;
	int          cyc = 0, n_under = 0, n_errors = 0, num_checks = 0, i;
	logic [7:0]  s_ctl [7] = '{8'h01, 8'h01, 8'h09, 8'h09, 8'h08, 8'h08, 8'h00};
	logic [7:0]  s_mode [7] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00};
	int          s_win [7] = '{256, 256, 16384, 4096, 2048, 2048, 2048};
	int          s_exp [7] = '{2, 4, 1, 2, 2, 2, 0};
	logic [7:0]  e_ctl [3] = '{8'h09, 8'h01, 8'h08};
	always #5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	always @(posedge aclk) if (sund === 1'b1) n_under <= n_under + 1;
	rtcs_top #(.EVAL_CHIP(1'b0)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.first_underflow(fu), .external_interrupt_two_pin(pin), .second_underflow(sund));
	rtcs_top #(.EVAL_CHIP(1'b1)) uut_eval (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
		.s_axi_rdata(e_rdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
		.first_underflow(fu), .external_interrupt_two_pin(pin), .second_underflow());
	task finish_test;
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task hang;
		n_errors++;
		$display("mismatch at %0t: bus wait ran out", $time);
		finish_test();
	endtask : hang
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int k;
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50 && !done; k++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				bready <= 1'b0;
				done = 1'b1;
				chk({30'h0, bresp}, {30'h0, er});
			end
		end
		if (!done) hang();
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50 && !done; k++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rready <= 1'b0;
				done = 1'b1;
				d = rdata;
				r = rresp;
				erd = e_rdata;
			end
		end
		if (!done) hang();
	endtask : axi_rd
	task wr(input logic [7:0] a, input logic [7:0] d);
		axi_wr(a, {24'h0, d}, 4'hF, rtcs_pkg::RESP_OKAY);
	endtask : wr
	task meas(input int w, input int exp, input int kind);
		int t0, k;
		logic [31:0] c0, c1;
		logic [1:0] r;
		t0 = cyc;
		axi_rd(rtcs_pkg::OFF_COUNT, c0, r);
		for (k = 0; k < 3 && kind == 1; k++) begin
			@(posedge aclk) fu <= 1'b1;
			@(posedge aclk) fu <= 1'b0;
		end
		for (k = 0; k < 3 && kind == 2; k++) begin
			@(posedge aclk) pin <= ~pin;
			repeat (4) @(posedge aclk);
		end
		while (cyc < t0 + w) @(posedge aclk);
		axi_rd(rtcs_pkg::OFF_COUNT, c1, r);
		chk((c0 - c1) & 32'hFF, exp);
	endtask : meas
	task t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(rtcs_pkg::OFF_CONTROL, d, r);
		chk(d, 32'h09);
		chk(erd, 32'h09);
		wr(rtcs_pkg::OFF_CONTROL, 8'h01);
		axi_wr(rtcs_pkg::OFF_CONTROL, 32'h08, 4'h0, rtcs_pkg::RESP_OKAY);
		axi_wr(8'h14, 32'h08, 4'hF, rtcs_pkg::RESP_SLVERR);
		axi_rd(rtcs_pkg::OFF_CONTROL, d, r);
		chk(d, 32'h01);
		chk(erd, 32'h09);
		axi_rd(8'h14, d, r);
		chk({30'h0, r}, {30'h0, rtcs_pkg::RESP_SLVERR});
	endtask : t_regs
	task t_sources;
		logic [31:0] d;
		logic [1:0] r;
		for (i = 0; i < 7; i++) begin
			wr(rtcs_pkg::OFF_CONTROL, s_ctl[i]);
			wr(rtcs_pkg::OFF_MODE, s_mode[i]);
			wr(rtcs_pkg::OFF_RELOAD, 8'hFF);
			meas(s_win[i], s_exp[i], 0);
			axi_rd(rtcs_pkg::OFF_STATUS, d, r);
			chk(d, (i == 6) ? 32'h01 : 32'h00);
		end
	endtask : t_sources
	task t_events;
		for (i = 0; i < 3; i++) begin
			wr(rtcs_pkg::OFF_CONTROL, e_ctl[i]);
			wr(rtcs_pkg::OFF_MODE, 8'h08);
			meas(20, 3, 1);
			wr(rtcs_pkg::OFF_MODE, 8'h0C);
			meas(30, 2, 2);
			wr(rtcs_pkg::OFF_MODE, 8'h0D);
			meas(30, 2, 2);
		end
	endtask : t_events
	task t_underflow;
		int n0;
		logic [31:0] d;
		logic [1:0] r;
		wr(rtcs_pkg::OFF_MODE, 8'h08);
		wr(rtcs_pkg::OFF_RELOAD, 8'h01);
		n0 = n_under;
		repeat (2) begin
			@(posedge aclk) fu <= 1'b1;
			@(posedge aclk) fu <= 1'b0;
		end
		repeat (4) @(posedge aclk);
		chk(n_under - n0, 1);
		axi_rd(rtcs_pkg::OFF_COUNT, d, r);
		chk(d, 32'h01);
		axi_rd(rtcs_pkg::OFF_STATUS, d, r);
		chk(d, 32'h02);
		wr(rtcs_pkg::OFF_STATUS, 8'h02);
		axi_rd(rtcs_pkg::OFF_STATUS, d, r);
		chk(d, 32'h00);
	endtask : t_underflow
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_sources();
		t_events();
		t_underflow();
		finish_test();
	end
endmodule : rtcs_top_tb
`default_nettype wire
